/* File: crd_pkg.sv */
package crd_pkg;

  // loop control modes
  typedef enum logic [2:0] {
    MODE_TIME_PROP_OR_ONOFF       = 3'h0,
    MODE_TIME_CYCLE_OR_ONOFF_CYC  = 3'h1,
    MODE_TIME_DUAL_OR_ONOFF_DUAL  = 3'h2,
    MODE_MOTOR_POSITION           = 3'h3,
    MODE_MULTI_RANGE              = 3'h4
  } crd_mode_t;

  // physical contact a loop output is routed to
  typedef enum logic [2:0] {
    CONTACT_NONE   = 3'h0,
    CONTACT_CTRL1  = 3'h1,
    CONTACT_CTRL2  = 3'h2,
    CONTACT_EVT3   = 3'h3,
    CONTACT_EVT2   = 3'h4,
    CONTACT_ANALOG = 3'h5
  } crd_contact_t;

  // derived calculation per value slot
  typedef enum logic [2:0] {
    CALC_NONE     = 3'h0,
    CALC_CARBON   = 3'h1,
    CALC_DEWPOINT = 3'h2,
    CALC_OXYGEN   = 3'h3,
    CALC_OXIDATION_REDUCTION_VALUE    = 3'h4
  } crd_calc_t;

  // register byte offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_ROUTE  = 4'h4;
  localparam logic [3:0] ADDR_SWITCH = 4'h8;

  // control register fields
  localparam int CTRL_L1_MODE_LSB = 0;
  localparam int CTRL_L2_MODE_LSB = 3;
  localparam int CTRL_L1_CYC_BIT  = 6;
  localparam int CTRL_AO1_SEL_BIT = 7;
  localparam int CTRL_AO2_SEL_BIT = 8;
  localparam int CTRL_WIDTH       = 9;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // switch bank 1 fields
  localparam int SW_CALC_LSB = 0;
  localparam int SW_DB_LSB   = 2;

  // deadband in tenths
  localparam logic [7:0] DB_CODE0 = 8'h02;
  localparam logic [7:0] DB_CODE1 = 8'h04;
  localparam logic [7:0] DB_CODE2 = 8'h0A;
  localparam logic [7:0] DB_CODE3 = 8'h14;
  localparam logic [7:0] DB_CODE4 = 8'h22;
  localparam logic [7:0] DB_CODE5 = 8'h34;
  localparam logic [7:0] DB_CODE6 = 8'h4A;

  localparam logic [3:0] MASTER_ADDR = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: crd_sync2.sv */
`timescale 1ns/1ps
module crd_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i, // clock
  input  wire logic             rst_n_i,    // sync reset, active low
  input  wire logic [WIDTH-1:0] async_i,    // pin level
  output logic      [WIDTH-1:0] sync_o      // synchronised level
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

/* File: crd_contact_routing_config_decode.sv */
`timescale 1ns/1ps
// Functional notes
// - event contacts 2/3 become control only when needed
// - loop2 multi-range bipolar after qualifying loop1 modes
// - analog out 1 spans positive loop2 half
// - analog out 2 spans negative loop2 half
// - one loop2-assigned analog output enables split
// - calc switches decode together; both off none
// - switch1 only: carbon slot0, dewpoint slot1
// - switch2 only: oxygen into both slots
// - both switches: oxidation_reduction_value into slot0
// - switches 5,4,3 select slidewire deadband
// - host address binary from four switches
// - address zero reserved for master computer
module crd_contact_routing_config_decode
  import crd_pkg::*;
#(
  parameter logic [7:0] DB_CODE7 = 8'h00
) (
  input  wire logic        core_clk_i,           // 200 MHz clock
  input  wire logic        rst_n_i,              // sync reset, active low
  input  wire logic        s_axi_awvalid,        // write address valid
  output logic             s_axi_awready,        // write address ready
  input  wire logic [3:0]  s_axi_awaddr,         // write address
  input  wire logic        s_axi_wvalid,         // write data valid
  output logic             s_axi_wready,         // write data ready
  input  wire logic [31:0] s_axi_wdata,          // write data
  input  wire logic [3:0]  s_axi_wstrb,          // byte enables
  output logic             s_axi_bvalid,         // write response valid
  input  wire logic        s_axi_bready,         // write response ready
  output logic [1:0]       s_axi_bresp,          // write response
  input  wire logic        s_axi_arvalid,        // read address valid
  output logic             s_axi_arready,        // read address ready
  input  wire logic [3:0]  s_axi_araddr,         // read address
  output logic             s_axi_rvalid,         // read data valid
  input  wire logic        s_axi_rready,         // read data ready
  output logic [31:0]      s_axi_rdata,          // read data
  output logic [1:0]       s_axi_rresp,          // read response
  input  wire logic [7:0]  calc_switch_bank_i,   // switch bank 1, bit0 = switch 1
  input  wire logic [3:0]  addr_switch_bank_i,   // switch bank 2, bit0 = switch 1
  output logic [2:0]       loop1_fwd_contact_o,  // loop 1 forward contact
  output logic [2:0]       loop1_rev_contact_o,  // loop 1 reverse contact
  output logic [2:0]       loop2_fwd_contact_o,  // loop 2 forward contact
  output logic [2:0]       loop2_rev_contact_o,  // loop 2 reverse contact
  output logic             evt2_as_ctrl_o,       // event 2 used for control
  output logic             evt3_as_ctrl_o,       // event 3 used for control
  output logic             loop2_bipolar_o,      // loop 2 spans -100..100
  output logic             ao1_split_pos_o,      // ao1 spans loop2 0..100
  output logic             ao2_split_neg_o,      // ao2 spans loop2 0..-100
  output logic [2:0]       calc_slot0_o,         // slot 0 calculation
  output logic [2:0]       calc_slot1_o,         // slot 1 calculation
  output logic [7:0]       deadband_tenths_o,    // slidewire deadband x10
  output logic [3:0]       host_addr_o,          // host network address
  output logic             host_addr_reserved_o  // address is the master's
);

  logic [7:0] bank1_s;
  logic [3:0] bank2_s;

  crd_sync2 #(.WIDTH(8)) u_sync_bank1 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (calc_switch_bank_i),
    .sync_o     (bank1_s)
  );

  crd_sync2 #(.WIDTH(4)) u_sync_bank2 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (addr_switch_bank_i),
    .sync_o     (bank2_s)
  );

  // register bus
  logic [CTRL_WIDTH-1:0] ctrl_reg;
  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [3:0]            awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  do_write;
  logic [31:0]           route_word;
  logic [31:0]           switch_word;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 4'h0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg     <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
      if (awaddr_reg == ADDR_CTRL)
      begin
        if (wstrb_reg[0])
          ctrl_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1])
          ctrl_reg[8] <= wdata_reg[8];
      end
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:   s_axi_rdata <= {23'h000000, ctrl_reg};
        ADDR_ROUTE:  s_axi_rdata <= route_word;
        ADDR_SWITCH: s_axi_rdata <= switch_word;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // mode decode
  logic [2:0] l1_mode;
  logic [2:0] l2_mode;
  logic       l1_qualifies;
  logic       l1_bipolar_ok;
  logic       split_on;

  assign l1_mode = ctrl_reg[CTRL_L1_MODE_LSB +: 3];
  assign l2_mode = ctrl_reg[CTRL_L2_MODE_LSB +: 3];
  assign l1_qualifies = (l1_mode == MODE_TIME_PROP_OR_ONOFF)
                     || (l1_mode == MODE_TIME_CYCLE_OR_ONOFF_CYC);
  // cycle group counts only in its on/off-cycle flavour
  assign l1_bipolar_ok = (l1_mode == MODE_TIME_PROP_OR_ONOFF)
                      || ((l1_mode == MODE_TIME_CYCLE_OR_ONOFF_CYC)
                          && ctrl_reg[CTRL_L1_CYC_BIT]);
  assign split_on = (l2_mode == MODE_MULTI_RANGE) && l1_qualifies
                 && (ctrl_reg[CTRL_AO1_SEL_BIT] || ctrl_reg[CTRL_AO2_SEL_BIT]);

  // mode-pair contact lookup
  crd_contact_t r1f;
  crd_contact_t r1r;
  crd_contact_t r2f;
  crd_contact_t r2r;

  always_comb
  begin
    r1f = CONTACT_CTRL1;
    r1r = CONTACT_NONE;
    r2f = CONTACT_NONE;
    r2r = CONTACT_NONE;
    case (l1_mode)
      MODE_TIME_PROP_OR_ONOFF:
        r1r = CONTACT_NONE;
      MODE_TIME_CYCLE_OR_ONOFF_CYC:
        r1r = (l2_mode == MODE_MULTI_RANGE) ? CONTACT_CTRL2 : CONTACT_EVT3;
      MODE_TIME_DUAL_OR_ONOFF_DUAL, MODE_MOTOR_POSITION:
        r1r = CONTACT_CTRL2;
      default:
        r1f = CONTACT_NONE;
    endcase
    case (l2_mode)
      MODE_MULTI_RANGE:
      begin
        if (l1_mode == MODE_TIME_PROP_OR_ONOFF)
        begin
          r2f = CONTACT_ANALOG;
          r2r = CONTACT_CTRL2;
        end
        else if (l1_mode == MODE_TIME_CYCLE_OR_ONOFF_CYC)
        begin
          r2f = CONTACT_EVT3;
          r2r = CONTACT_ANALOG;
        end
        else
        begin
          r2f = CONTACT_ANALOG;
          r2r = CONTACT_ANALOG;
        end
      end
      MODE_TIME_PROP_OR_ONOFF, MODE_TIME_CYCLE_OR_ONOFF_CYC,
      MODE_TIME_DUAL_OR_ONOFF_DUAL, MODE_MOTOR_POSITION:
      begin
        if (l1_mode == MODE_TIME_PROP_OR_ONOFF || l1_mode == MODE_TIME_CYCLE_OR_ONOFF_CYC)
          r2f = CONTACT_CTRL2;
        else
          r2f = CONTACT_EVT3;
        if (l2_mode == MODE_TIME_PROP_OR_ONOFF)
          r2r = CONTACT_NONE;
        else if (l1_mode == MODE_TIME_PROP_OR_ONOFF)
          r2r = CONTACT_EVT3;
        else
          r2r = CONTACT_EVT2;
      end
      default:
      begin
        r2f = CONTACT_NONE;
        r2r = CONTACT_NONE;
      end
    endcase
    if (r1f == CONTACT_NONE)
    begin
      r1r = CONTACT_NONE;
      r2f = CONTACT_NONE;
      r2r = CONTACT_NONE;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      loop1_fwd_contact_o <= CONTACT_NONE;
      loop1_rev_contact_o <= CONTACT_NONE;
      loop2_fwd_contact_o <= CONTACT_NONE;
      loop2_rev_contact_o <= CONTACT_NONE;
      evt2_as_ctrl_o      <= 1'b0;
      evt3_as_ctrl_o      <= 1'b0;
    end
    else
    begin
      loop1_fwd_contact_o <= r1f;
      loop1_rev_contact_o <= r1r;
      loop2_fwd_contact_o <= r2f;
      loop2_rev_contact_o <= r2r;
      evt2_as_ctrl_o <= (r1r == CONTACT_EVT2) || (r2f == CONTACT_EVT2)
                     || (r2r == CONTACT_EVT2);
      evt3_as_ctrl_o <= (r1r == CONTACT_EVT3) || (r2f == CONTACT_EVT3)
                     || (r2r == CONTACT_EVT3);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      loop2_bipolar_o <= 1'b0;
      ao1_split_pos_o <= 1'b0;
      ao2_split_neg_o <= 1'b0;
    end
    else
    begin
      loop2_bipolar_o <= (l2_mode == MODE_MULTI_RANGE) && l1_bipolar_ok;
      ao1_split_pos_o <= split_on && ctrl_reg[CTRL_AO1_SEL_BIT];
      ao2_split_neg_o <= split_on && ctrl_reg[CTRL_AO2_SEL_BIT];
    end
  end

  // switch decode
  logic [1:0] calc_sel;
  logic [2:0] db_sel;

  assign calc_sel = bank1_s[SW_CALC_LSB +: 2];
  assign db_sel   = bank1_s[SW_DB_LSB +: 3];

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      calc_slot0_o <= CALC_NONE;
      calc_slot1_o <= CALC_NONE;
    end
    else
    begin
      case (calc_sel)
        2'h1:
        begin
          calc_slot0_o <= CALC_CARBON;
          calc_slot1_o <= CALC_DEWPOINT;
        end
        2'h2:
        begin
          calc_slot0_o <= CALC_OXYGEN;
          calc_slot1_o <= CALC_OXYGEN;
        end
        2'h3:
        begin
          calc_slot0_o <= CALC_OXIDATION_REDUCTION_VALUE;
          calc_slot1_o <= CALC_NONE;
        end
        default:
        begin
          calc_slot0_o <= CALC_NONE;
          calc_slot1_o <= CALC_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      deadband_tenths_o <= DB_CODE0;
    else
    begin
      case (db_sel)
        3'h0:    deadband_tenths_o <= DB_CODE0;
        3'h1:    deadband_tenths_o <= DB_CODE1;
        3'h2:    deadband_tenths_o <= DB_CODE2;
        3'h3:    deadband_tenths_o <= DB_CODE3;
        3'h4:    deadband_tenths_o <= DB_CODE4;
        3'h5:    deadband_tenths_o <= DB_CODE5;
        3'h6:    deadband_tenths_o <= DB_CODE6;
        default: deadband_tenths_o <= DB_CODE7;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      host_addr_o          <= MASTER_ADDR;
      host_addr_reserved_o <= 1'b1;
    end
    else
    begin
      host_addr_o          <= bank2_s;
      host_addr_reserved_o <= (bank2_s == MASTER_ADDR);
    end
  end

  assign route_word = {15'h0000, ao2_split_neg_o, ao1_split_pos_o, loop2_bipolar_o,
                       evt3_as_ctrl_o, evt2_as_ctrl_o, loop2_rev_contact_o,
                       loop2_fwd_contact_o, loop1_rev_contact_o, loop1_fwd_contact_o};
  assign switch_word = {11'h000, host_addr_reserved_o, host_addr_o, deadband_tenths_o,
                        2'h0, calc_slot1_o, calc_slot0_o};

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  evt_reuse_a: assert property (
    (l1_mode == MODE_TIME_PROP_OR_ONOFF && l2_mode == MODE_TIME_PROP_OR_ONOFF)
    |=> (!evt2_as_ctrl_o && !evt3_as_ctrl_o))
    else $error("event contacts taken for control when not needed");

  mode_lookup_a: assert property (
    (l1_mode == MODE_TIME_CYCLE_OR_ONOFF_CYC && l2_mode == MODE_TIME_CYCLE_OR_ONOFF_CYC)
    |=> (loop1_rev_contact_o == CONTACT_EVT3 && loop2_rev_contact_o == CONTACT_EVT2
         && evt2_as_ctrl_o))
    else $error("cycle/cycle routing wrong");

  bipolar_mode_a: assert property (
    (l2_mode == MODE_MULTI_RANGE && l1_mode == MODE_TIME_DUAL_OR_ONOFF_DUAL)
    |=> !loop2_bipolar_o)
    else $error("loop 2 bipolar in wrong mode");

  ao1_span_a: assert property (
    $past(rst_n_i) |-> (ao1_split_pos_o == ($past(l2_mode) == MODE_MULTI_RANGE
      && $past(l1_qualifies) && $past(ctrl_reg[CTRL_AO1_SEL_BIT]))))
    else $error("analog 1 split wrong");

  ao2_span_a: assert property (
    ao2_split_neg_o |-> $past(ctrl_reg[CTRL_AO2_SEL_BIT]) && $past(l1_qualifies))
    else $error("analog 2 split wrong");

  split_one_a: assert property (
    (split_on && !ctrl_reg[CTRL_AO2_SEL_BIT]) |=> ao1_split_pos_o && !ao2_split_neg_o)
    else $error("single assignment did not split");

  calc_off_a: assert property (
    (calc_sel == 2'h0) |=> (calc_slot0_o == CALC_NONE && calc_slot1_o == CALC_NONE))
    else $error("calculation active with switches off");

  calc_carbon_a: assert property (
    (calc_sel == 2'h1) |=> (calc_slot0_o == CALC_CARBON && calc_slot1_o == CALC_DEWPOINT))
    else $error("carbon decode wrong");

  calc_oxygen_a: assert property (
    (calc_sel == 2'h2) |=> (calc_slot0_o == CALC_OXYGEN && calc_slot1_o == CALC_OXYGEN))
    else $error("oxygen decode wrong");

  calc_oxidation_reduction_value_a: assert property (
    (calc_sel == 2'h3) |=> (calc_slot0_o == CALC_OXIDATION_REDUCTION_VALUE))
    else $error("oxidation_reduction_value decode wrong");

  deadband_code_a: assert property (
    (db_sel == 3'h4) |=> (deadband_tenths_o == 8'h22))
    else $error("deadband code 4 wrong");

  deadband_spare_a: assert property (
    (db_sel == 3'h7) |=> (deadband_tenths_o == DB_CODE7))
    else $error("deadband code 7 wrong");

  host_addr_a: assert property (
    $past(rst_n_i, 3) && $stable(addr_switch_bank_i) [*3] |-> host_addr_o
      == $past(addr_switch_bank_i, 3))
    else $error("host address not from switches");

  master_addr_a: assert property (
    $past(rst_n_i) |-> (host_addr_reserved_o == (host_addr_o == MASTER_ADDR)))
    else $error("reserved flag disagrees with address");

endmodule

/* File: crd_contact_routing_config_decode_tb.sv */
`timescale 1ns/1ps
module crd_contact_routing_config_decode_tb
  import crd_pkg::*;
;
  localparam logic [7:0]  DBX = 8'h5A;
  localparam logic [7:0]  DBT [8] = '{DB_CODE0, DB_CODE1, DB_CODE2, DB_CODE3, DB_CODE4,
                                      DB_CODE5, DB_CODE6, DBX};
  // nibbles: loop1 fwd, loop1 rev, loop2 fwd, loop2 rev; index loop2 * 4 + loop1
  localparam logic [15:0] TBL [20] = '{16'h1020, 16'h1320, 16'h1230, 16'h1230,
                                       16'h1023, 16'h1324, 16'h1234, 16'h1234,
                                       16'h1023, 16'h1324, 16'h1234, 16'h1234,
                                       16'h1023, 16'h1324, 16'h1234, 16'h1234,
                                       16'h1052, 16'h1235, 16'h1255, 16'h1255};
  logic        clk;
  logic        rst_n;
  logic        awvalid, wvalid, bready, arvalid, rready, snap;
  logic [3:0]  awaddr, wstrb, araddr, addr_sw;
  logic [31:0] wdata, rnd;
  logic [7:0]  calc_sw;
  logic [8:0]  cur;
  wire         awready, wready, bvalid, arready, rvalid, evt2, evt3, bip, ao1, ao2, resv;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [2:0]  l1f, l1r, l2f, l2r, slot0, slot1;
  wire  [7:0]  dband;
  wire  [3:0]  haddr;
  int          error_cnt;
  int          checked;
  logic [33:0] rq [$];
  logic [1:0]  wq [$];
  logic [37:0] pq [$];

  crd_contact_routing_config_decode #(.DB_CODE7(DBX)) DUT (
    .core_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .calc_switch_bank_i(calc_sw), .addr_switch_bank_i(addr_sw),
    .loop1_fwd_contact_o(l1f), .loop1_rev_contact_o(l1r),
    .loop2_fwd_contact_o(l2f), .loop2_rev_contact_o(l2r),
    .evt2_as_ctrl_o(evt2), .evt3_as_ctrl_o(evt3), .loop2_bipolar_o(bip),
    .ao1_split_pos_o(ao1), .ao2_split_neg_o(ao2),
    .calc_slot0_o(slot0), .calc_slot1_o(slot1), .deadband_tenths_o(dband),
    .host_addr_o(haddr), .host_addr_reserved_o(resv)
  );

  function automatic logic [16:0] route_exp(input logic [8:0] c);
    logic [15:0] t;
    logic        mrm;
    logic        q;
    logic        e2;
    logic        e3;
    t = TBL[c[5:3] * 4 + c[2:0]];
    e2 = 1'b0;
    e3 = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      e2 = e2 | (t[i*4+:3] == 3'h4);
      e3 = e3 | (t[i*4+:3] == 3'h3);
    end
    mrm = c[5:3] == 3'h4;
    q = c[2:0] < 3'h2;
    return {mrm & q & c[8], mrm & q & c[7], mrm & (c[2:0] == 3'h0 | (c[2:0] == 3'h1 & c[6])),
            e3, e2, t[2:0], t[6:4], t[10:8], t[14:12]};
  endfunction

  function automatic logic [20:0] sw_exp(input logic [7:0] c, input logic [3:0] a);
    logic [2:0] s0;
    logic [2:0] s1;
    s0 = c[1:0] == 2'h1 ? CALC_CARBON : c[1:0] == 2'h2 ? CALC_OXYGEN :
         c[1:0] == 2'h3 ? CALC_OXIDATION_REDUCTION_VALUE : CALC_NONE;
    s1 = c[1:0] == 2'h1 ? CALC_DEWPOINT : c[1:0] == 2'h2 ? CALC_OXYGEN : CALC_NONE;
    return {a == MASTER_ADDR, a, DBT[c[4:2]], 2'h0, s1, s0};
  endfunction

  task automatic fail(input logic [37:0] e, input logic [37:0] g);
    error_cnt++;
    $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
  endtask

  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e)
      fail(e, g);
  endtask

  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e)
      fail(e, g);
  endtask

  task automatic cmp_port(input logic [37:0] e, input logic [37:0] g);
    checked++;
    if (g !== e)
      fail(e, g);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ah;
    logic wh;
    logic bh;
    int   n;
    wq.push_back(er);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    n = 0;
    bh = 1'b0;
    while (!bh && n < 100)
    begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      @(posedge clk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!bh)
      fail(38'h0, 38'h1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    logic ah;
    logic rh;
    int   n;
    rq.push_back(e);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    n = 0;
    rh = 1'b0;
    while (!rh && n < 100)
    begin
      @(negedge clk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      @(posedge clk);
      if (ah)
        arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!rh)
      fail(38'h0, 38'h1);
  endtask

  // snapshot of the decode outputs against the current settings
  task automatic pk();
    pq.push_back({route_exp(cur), sw_exp(calc_sw, addr_sw)});
    @(posedge clk);
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
    @(posedge clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(negedge clk)
  begin
    if (rvalid && rready)
      cmp_rd(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready)
      cmp_wr(wq.pop_front(), bresp);
    if (snap)
      cmp_port(pq.pop_front(), {ao2, ao1, bip, evt3, evt2, l2r, l2f, l1r, l1f,
                                resv, haddr, dband, 2'h0, slot1, slot0});
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, snap} = 6'h00;
    {awaddr, wstrb, araddr} = 12'h000;
    wdata = 32'h0;
    calc_sw = 8'h09;
    addr_sw = 4'h0;
    cur = 9'h000;
    error_cnt = 0;
    checked = 0;
    rst_n = 1'b0;
    void'($urandom(32'h9E74));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ADDR_CTRL, {RESP_OKAY, 32'h0});
    rd(ADDR_ROUTE, {RESP_OKAY, 15'h0, route_exp(cur)});
    pk();
    $display("reset values done");
    for (int l2 = 0; l2 < 5; l2++)
      for (int l1 = 0; l1 < 4; l1++)
        for (int c = 0; c < 2; c++)
        begin
          rnd = $urandom();
          cur = {rnd[31:30], c[0], l2[2:0], l1[2:0]};
          wr(ADDR_CTRL, {rnd[22:0], cur}, 4'hF, RESP_OKAY);
          rd(ADDR_CTRL, {RESP_OKAY, 23'h0, cur});
          rd(ADDR_ROUTE, {RESP_OKAY, 15'h0, route_exp(cur)});
          pk();
        end
    $display("mode pair routing done");
    for (int k = 0; k < 32; k++)
    begin
      rnd = $urandom();
      calc_sw <= {rnd[7:5], k[4:0]};
      addr_sw <= k[3:0];
      repeat (4) @(posedge clk);
      rd(ADDR_SWITCH, {RESP_OKAY, 11'h0, sw_exp(calc_sw, addr_sw)});
      pk();
    end
    $display("switch decode done");
    cur = 9'h120;
    wr(ADDR_CTRL, 32'h0000_0120, 4'hF, RESP_OKAY);
    pk();
    cur = 9'h1E1;
    wr(ADDR_CTRL, 32'hFFFF_FEE1, 4'h1, RESP_OKAY);
    rd(ADDR_CTRL, {RESP_OKAY, 23'h0, cur});
    pk();
    wr(ADDR_ROUTE, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    wr(4'hC, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    rd(4'hC, {RESP_SLVERR, 32'h0});
    rd(ADDR_ROUTE, {RESP_OKAY, 15'h0, route_exp(cur)});
    $display("strobe and error access done");
    wr(ADDR_CTRL, 32'h0000_0028, 4'hF, RESP_OKAY);
    rd(ADDR_ROUTE, {RESP_OKAY, 32'h0000_0001});
    wr(ADDR_CTRL, 32'h0000_002F, 4'hF, RESP_OKAY);
    rd(ADDR_ROUTE, {RESP_OKAY, 32'h0000_0000});
    $display("invalid mode routing done");
    finish_test();
  end
endmodule
